// File: inc/pcst_pkg.sv
// constants and types for the preset counter self-test block
package pcst_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int WALK_MS = 500;
	localparam int STATUS_MS = 2000;
	localparam int IDLE_S = 18;
	localparam logic [10:0] WALK_TICKS = 11'(WALK_MS / TICK_MS);
	localparam logic [10:0] STATUS_TICKS = 11'(STATUS_MS / TICK_MS);
	localparam logic [10:0] IDLE_TICKS = 11'(IDLE_S * 1000 / TICK_MS);
	// button bits: 5..0 digit buttons left to right, rightmost is preset one
	localparam int BTN_PRESET_ONE = 0;
	localparam int BTN_PRESET_TWO = 1;
	localparam int BTN_PRESCALE_KEY = 2;
	localparam int BTN_NEXT_LEFT = 4;
	localparam int BTN_LEFT = 5;
	localparam int BTN_ENTER = 6;
	localparam int BTN_RESET = 7;
	// switch bits: bit i is switch i+1, high means switch down
	localparam int SW_RESET_DIS = 1;
	localparam int SW_MODE_MSB = 2;
	localparam int SW_PRESCALE_EDIT = 6;
	localparam logic [7:0] OFF_PRESET_ONE = 8'h00;
	localparam logic [7:0] OFF_PRESET_TWO = 8'h04;
	localparam logic [7:0] OFF_PRESCALE = 8'h08;
	localparam logic [7:0] OFF_TIMED_ONE = 8'h0c;
	localparam logic [7:0] OFF_TIMED_TWO = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [2:0] IDX_PRESCALE = 3'h2;
	localparam logic [2:0] IDX_STATUS = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;
	localparam logic [19:0] RST_PRESET_ONE = 20'h001f4;
	localparam logic [19:0] RST_PRESET_TWO = 20'h003e8;
	localparam logic [19:0] RST_PRESCALE = 20'h186a0;
	localparam logic [19:0] RST_TIMED = 20'h0000a;
	localparam logic [20:0] PS_UNIT = 21'h186a0;
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_TESTED = 2;
	localparam int ST_OUT1 = 3;
	localparam int ST_OUT2 = 4;
	localparam int ST_MODE_LSB = 8;
	localparam int ST_DIGITS_LSB = 12;
	localparam int ST_EDIT_OK = 16;
	typedef enum logic [1:0] {PH_IDLE, PH_WALK, PH_STATUS, PH_MODE} pcst_phase_t;
endpackage

// File: verif/pcst_operator.sv
// front panel operator model driving the button lines
`timescale 1ns/100ps
module pcst_operator (
	input wire logic i_clk,
	output logic [7:0] o_btn
);
	initial o_btn = 8'h00;
	// buttons go fully released between presses; no bounce is modelled
	task automatic press(input logic [7:0] mask, input int n);
		@(posedge i_clk);
		o_btn <= mask;
		repeat (n) @(posedge i_clk);
		o_btn <= 8'h00;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
endmodule // pcst_operator

// File: verif/pcst_top_tb.sv
// self-checking bench for the self-test sequencer
`timescale 1ns/100ps
module pcst_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic lock = 1'b1;
	logic pulse = 1'b0;
	logic run1 = 1'b0;
	logic run2 = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [6:0] sw = 7'h7d;
	logic [31:0] prdata, rd;
	logic pready, pslverr, out1, out2, oclr, ures, er, eok;
	logic [1:0] phase;
	logic [5:0] walk;
	logic [3:0] dig, mode, cadd;
	logic [19:0] p1, p2, t1, t2;
	wire [7:0] btn;
	int failures = 0;
	int n_checks = 0;
	int nclr = 0;
	int nres = 0;
	int cyc = 0;
	int seed = 13;
	int acc = 0;
	int kval, i;

	pcst_top #(.TICK_CYCLES(4)) dut (
		.I_CLK_SYS(clk), .I_RESET(rst), .I_BTN(btn), .I_DIP_SW(sw),
		.I_PROGRAM_LOCK_INPUT(lock), .I_COUNT_PULSE(pulse),
		.I_RUN_OUT1(run1), .I_RUN_OUT2(run2), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_OUT1(out1), .O_OUT2(out2),
		.O_OUT_CLEAR(oclr), .O_UNIT_RESET(ures), .O_PHASE(phase),
		.O_WALK_DIGIT(walk), .O_ST_DIGITS(dig), .O_MODE(mode),
		.O_COUNT_ADD(cadd), .O_PRESET_ONE(p1), .O_PRESET_TWO(p2),
		.O_TIMED_ONE(t1), .O_TIMED_TWO(t2), .O_PRESCALE_EDIT_OK(eok)
	);
	pcst_operator op (.i_clk(clk), .o_btn(btn));

	always #20 clk = ~clk;

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// stands in for the counting logic, which drops its latches on request
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (oclr === 1'b1) begin
			run1 <= 1'b0;
			run2 <= 1'b0;
			nclr <= nclr + 1;
		end
		if (ures === 1'b1) nres <= nres + 1;
		if (cyc == 40000) begin
			failures++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_ph(input logic [1:0] p, input int n);
		for (int k = 0; k < n && phase !== p; k++) @(posedge clk);
		#1;
	endtask

	// data and response are taken at the edge that finds pready high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	function automatic logic [3:0] scale(input int k);
		acc = acc + k;
		scale = 4'(acc / 100000);
		acc = acc % 100000;
	endfunction

	function automatic logic [3:0] rev(input logic [6:0] s);
		rev = {s[2], s[3], s[4], s[5]};
	endfunction

	// applied mode: shown pattern inverted, leftmost switch as msb
	function automatic logic [3:0] mode_of(input logic [6:0] s);
		mode_of = ~rev(s);
	endfunction

	task automatic cnt(input logic [3:0] e);
		@(posedge clk);
		pulse <= 1'b1;
		@(posedge clk);
		pulse <= 1'b0;
		#1;
		chk("count_add", 32'(e), 32'(cadd));
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk("preset_one", 32'h1f4, 32'(p1));
		chk("preset_two", 32'h3e8, 32'(p2));
		chk("timed_one", 32'ha, 32'(t1));
		chk("timed_two", 32'ha, 32'(t2));
		chk("mode", 32'h0, 32'(mode));
		chk("edit_ok", 32'h1, 32'(eok));
		apb(1'b0, 8'h08, 32'h0);
		chk("prescale", 32'h186a0, rd);
		cnt(4'h1);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, 32'(er));
		apb(1'b0, 8'h14, 32'h0);
		chk("status_reg", 32'h10000, rd);
		$display("test defaults done");
		lock <= 1'b0;
		apb(1'b1, 8'h08, 32'h30d40);
		chk("lock_refuse", 32'h1, 32'(er));
		lock <= 1'b1;
		sw[6] <= 1'b0;
		apb(1'b1, 8'h08, 32'h30d40);
		chk("sw7_refuse", 32'h1, 32'(er));
		chk("edit_off", 32'h0, 32'(eok));
		sw[6] <= 1'b1;
		apb(1'b0, 8'h08, 32'h0);
		chk("no_store", 32'h186a0, rd);
		kval = 1 + int'($unsigned($random(seed)) % 999999);
		apb(1'b1, 8'h08, 32'(kval));
		chk("k_write", 32'h0, 32'(er));
		for (i = 0; i < 6; i++) cnt(scale(kval));
		$display("test prescale done");
		@(posedge clk);
		run1 <= 1'b1;
		op.press(8'h30, 2);
		chk("walk_phase", 32'h1, 32'(phase));
		chk("walk_first", 32'h20, 32'(walk));
		@(posedge clk);
		run1 <= 1'b0;
		cnt(scale(kval));
		chk("out1_hold", 32'h1, 32'(out1));
		wait_ph(2'h2, 1400);
		chk("status_phase", 32'h2, 32'(phase));
		chk("status", 32'h0, 32'(dig));
		wait_ph(2'h3, 1000);
		chk("mode_show", 32'(rev(sw)), 32'(dig));
		@(posedge clk);
		sw[5:2] <= 4'($random(seed));
		tick(3);
		chk("mode_live", 32'(rev(sw)), 32'(dig));
		chk("mode_frozen", 32'h0, 32'(mode));
		op.press(8'h03, 2);
		chk("out_test", 32'h1, 32'(out1));
		chk("out_test2", 32'h1, 32'(out2));
		op.press(8'h40, 2);
		chk("exit", 32'h0, 32'(phase));
		chk("cleared", 32'h1, 32'(nclr));
		chk("out1_off", 32'h0, 32'(out1));
		chk("mode_apply", 32'(mode_of(sw)), 32'(mode));
		$display("test output self-test done");
		@(posedge clk);
		run1 <= 1'b1;
		sw[6] <= 1'b0;
		lock <= 1'b0;
		op.press(8'h30, 2);
		op.press(8'h04, 1);
		chk("advance", 32'h10, 32'(walk));
		for (i = 0; i < 8 && phase !== 2'h2; i++) op.press(8'h40, 1);
		chk("status_b", 32'h3, 32'(dig));
		@(posedge clk);
		run1 <= 1'b0;
		op.press(8'h40, 1);
		chk("mode_phase", 32'h3, 32'(phase));
		op.press(8'h02, 2);
		chk("out_locked", 32'h0, 32'(out2));
		chk("out1_kept", 32'h1, 32'(out1));
		tick(7000);
		chk("idle_wait", 32'h3, 32'(phase));
		wait_ph(2'h0, 600);
		chk("idle_exit", 32'h0, 32'(phase));
		chk("no_clear", 32'h1, 32'(nclr));
		$display("test idle exit done");
		@(posedge clk);
		sw <= 7'h7d;
		lock <= 1'b1;
		op.press(8'h30, 2);
		op.press(8'h80, 1);
		chk("unit_reset", 32'h1, 32'(nres));
		chk("abort", 32'h0, 32'(phase));
		op.press(8'h81, 1);
		chk("reset_except", 32'h1, 32'(nres));
		@(posedge clk);
		sw[1] <= 1'b1;
		op.press(8'h80, 1);
		chk("reset_dis", 32'h1, 32'(nres));
		$display("test reset button done");
		test_done();
	end
endmodule // pcst_top_tb

// File: verilog/pcst_top.sv
// self-test sequencer, stored values and prescale scaling of the counter
`timescale 1ns/100ps
module pcst_top #(
	parameter int TICK_CYCLES = pcst_pkg::TICK_CYCLES
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic [7:0] I_BTN,
	input wire logic [6:0] I_DIP_SW,
	input wire logic I_PROGRAM_LOCK_INPUT,
	input wire logic I_COUNT_PULSE,
	input wire logic I_RUN_OUT1,
	input wire logic I_RUN_OUT2,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_OUT1,
	output logic O_OUT2,
	output logic O_OUT_CLEAR,
	output logic O_UNIT_RESET,
	output logic [1:0] O_PHASE,
	output logic [5:0] O_WALK_DIGIT,
	output logic [3:0] O_ST_DIGITS,
	output logic [3:0] O_MODE,
	output logic [3:0] O_COUNT_ADD,
	output logic [19:0] O_PRESET_ONE,
	output logic [19:0] O_PRESET_TWO,
	output logic [19:0] O_TIMED_ONE,
	output logic [19:0] O_TIMED_TWO,
	output logic O_PRESCALE_EDIT_OK
);
	localparam int TW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		pcst_pkg::pcst_phase_t phase;
		logic [5:0] walk;
		logic [TW-1:0] tick_cnt;
		logic [10:0] sec_cnt;
		logic armed;
		logic tested;
		logic [7:0] btn_q;
		logic [6:0] sw_q;
		logic [3:0] mode;
		logic [3:0] st_digits;
		logic out1;
		logic out2;
		logic out_clear;
		logic unit_reset;
		logic edit_ok;
		logic [4:0][19:0] vals;
		logic [16:0] acc;
		logic [3:0] add;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pcst_state_t;

	pcst_state_t s;
	pcst_state_t next_s;
	logic tick;
	logic activity;

	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		unique case (addr)
			pcst_pkg::OFF_PRESET_ONE: reg_index = 3'h0;
			pcst_pkg::OFF_PRESET_TWO: reg_index = 3'h1;
			pcst_pkg::OFF_PRESCALE: reg_index = pcst_pkg::IDX_PRESCALE;
			pcst_pkg::OFF_TIMED_ONE: reg_index = 3'h3;
			pcst_pkg::OFF_TIMED_TWO: reg_index = 3'h4;
			pcst_pkg::OFF_STATUS: reg_index = pcst_pkg::IDX_STATUS;
			default: reg_index = pcst_pkg::IDX_NONE;
		endcase
	endfunction

	// whole display units in sum; a full 20-bit prescale plus the carried
	// remainder gives eleven at most, so the remainder always fits acc
	function automatic logic [3:0] scale_units(input logic [20:0] sum);
		logic [3:0] u;
		u = 4'h0;
		for (int i = 1; i < 12; i++) begin
			if (sum >= 21'(i) * pcst_pkg::PS_UNIT) begin
				u = 4'(i);
			end
		end
		return u;
	endfunction

	always_comb begin
		logic [7:0] pressed;
		logic [7:0] released;
		logic advance;
		logic lock_on;
		logic quit;
		logic [20:0] sum;
		logic [3:0] units;
		logic [2:0] idx;
		pressed = I_BTN & ~s.btn_q;
		released = ~I_BTN & s.btn_q;
		lock_on = ~I_PROGRAM_LOCK_INPUT;
		quit = 1'b0;
		sum = 21'h00000;
		units = 4'h0;
		idx = reg_index(I_PADDR);
		next_s = s;
		next_s.out_clear = 1'b0;
		next_s.unit_reset = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.add = 4'h0;
		next_s.btn_q = I_BTN;
		next_s.sw_q = I_DIP_SW;
		tick = (s.tick_cnt == TW'(TICK_CYCLES - 1));
		next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
		activity = (I_BTN != s.btn_q) || (I_DIP_SW != s.sw_q);
		// releases of the entry pair must not count as a step
		advance = s.armed && (|released[6:0]);
		if (I_BTN == 8'h00) begin
			next_s.armed = 1'b1;
		end
		if (tick) begin
			next_s.sec_cnt = s.sec_cnt + 11'h001;
		end
		unique case (s.phase)
			pcst_pkg::PH_IDLE: begin
				if (I_BTN[pcst_pkg::BTN_LEFT] && I_BTN[pcst_pkg::BTN_NEXT_LEFT]
					&& (pressed[pcst_pkg::BTN_LEFT]
					|| pressed[pcst_pkg::BTN_NEXT_LEFT])) begin
					next_s.phase = pcst_pkg::PH_WALK;
					next_s.walk = 6'h20;
					next_s.sec_cnt = 11'h000;
					next_s.armed = 1'b0;
					next_s.tested = 1'b0;
				end
			end
			pcst_pkg::PH_WALK: begin
				if (advance || (tick && s.sec_cnt == pcst_pkg::WALK_TICKS - 11'h001))
					begin
					next_s.sec_cnt = 11'h000;
					next_s.walk = s.walk >> 1;
					if (s.walk[0]) begin
						next_s.phase = pcst_pkg::PH_STATUS;
					end
				end
			end
			pcst_pkg::PH_STATUS: begin
				if (advance
					|| (tick && s.sec_cnt == pcst_pkg::STATUS_TICKS - 11'h001)) begin
					next_s.sec_cnt = 11'h000;
					next_s.phase = pcst_pkg::PH_MODE;
				end
			end
			pcst_pkg::PH_MODE: begin
				if (activity) begin
					next_s.sec_cnt = 11'h000;
				end
				if (!lock_on) begin
					if (pressed[pcst_pkg::BTN_PRESET_ONE]) begin
						next_s.tested = 1'b1;
						next_s.out1 = 1'b1;
					end
					if (pressed[pcst_pkg::BTN_PRESET_TWO]) begin
						next_s.tested = 1'b1;
						next_s.out2 = 1'b1;
					end
				end
				// with the lock open, preset buttons test outputs here; releasing enter or buttons 2 to 5 leaves
				quit = (s.armed && (|released[6:2]))
					|| (tick && !activity
					&& s.sec_cnt == pcst_pkg::IDLE_TICKS - 11'h001);
				if (quit) begin
					next_s.phase = pcst_pkg::PH_IDLE;
					if (s.tested) begin
						next_s.out_clear = 1'b1;
					end
				end
			end
		endcase
		if (pressed[pcst_pkg::BTN_RESET] && !I_DIP_SW[pcst_pkg::SW_RESET_DIS]
			&& !I_BTN[pcst_pkg::BTN_PRESET_ONE]
			&& !I_BTN[pcst_pkg::BTN_PRESET_TWO]) begin
			next_s.unit_reset = 1'b1;
			next_s.phase = pcst_pkg::PH_IDLE;
			next_s.out_clear = 1'b1;
		end
		if (next_s.phase == pcst_pkg::PH_IDLE) begin
			next_s.walk = 6'h00;
			next_s.tested = 1'b0;
			// leftmost mode switch is the msb; all down selects mode zero
			next_s.mode = ~{I_DIP_SW[2], I_DIP_SW[3],
				I_DIP_SW[4], I_DIP_SW[5]};
			if (next_s.out_clear) begin
				next_s.out1 = 1'b0;
				next_s.out2 = 1'b0;
			end else begin
				next_s.out1 = I_RUN_OUT1;
				next_s.out2 = I_RUN_OUT2;
			end
		end
		// untested outputs are simply not reloaded while the test runs
		unique case (next_s.phase)
			pcst_pkg::PH_STATUS: begin
				next_s.st_digits = {2'b00,
					~I_DIP_SW[pcst_pkg::SW_PRESCALE_EDIT], lock_on};
			end
			pcst_pkg::PH_MODE: next_s.st_digits = {I_DIP_SW[2], I_DIP_SW[3],
				I_DIP_SW[4], I_DIP_SW[5]};
			default: next_s.st_digits = 4'h0;
		endcase
		next_s.edit_ok = I_DIP_SW[pcst_pkg::SW_PRESCALE_EDIT]
			&& !lock_on;
		if (I_COUNT_PULSE) begin
			sum = 21'(s.acc) + 21'(s.vals[pcst_pkg::IDX_PRESCALE]);
			units = scale_units(sum);
			next_s.add = units;
			next_s.acc = 17'(sum - 21'(units) * pcst_pkg::PS_UNIT);
		end
		if (I_PSEL && !I_PENABLE) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h00000000;
			if (idx == pcst_pkg::IDX_NONE) begin
				next_s.pslverr = 1'b1;
			end else if (idx == pcst_pkg::IDX_STATUS) begin
				next_s.pslverr = I_PWRITE;
				next_s.prdata[pcst_pkg::ST_PHASE_LSB +: 2] = s.phase;
				next_s.prdata[pcst_pkg::ST_TESTED] = s.tested;
				next_s.prdata[pcst_pkg::ST_OUT1] = s.out1;
				next_s.prdata[pcst_pkg::ST_OUT2] = s.out2;
				next_s.prdata[pcst_pkg::ST_MODE_LSB +: 4] = s.mode;
				next_s.prdata[pcst_pkg::ST_DIGITS_LSB +: 4] = s.st_digits;
				next_s.prdata[pcst_pkg::ST_EDIT_OK] = s.edit_ok;
			end else begin
				next_s.prdata[19:0] = s.vals[idx];
				// any stored value needs the lock open; prescale also needs S7
				if (I_PWRITE && (lock_on || (idx == pcst_pkg::IDX_PRESCALE
					&& !I_DIP_SW[pcst_pkg::SW_PRESCALE_EDIT]))) begin
					next_s.pslverr = 1'b1;
				end
			end
		end
		if (I_PSEL && I_PENABLE && s.pready && I_PWRITE && !s.pslverr
			&& idx < pcst_pkg::IDX_STATUS) begin
			next_s.vals[idx] = I_PWDATA[19:0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			s <= '0;
			s.vals[0] <= pcst_pkg::RST_PRESET_ONE;
			s.vals[1] <= pcst_pkg::RST_PRESET_TWO;
			s.vals[pcst_pkg::IDX_PRESCALE] <= pcst_pkg::RST_PRESCALE;
			s.vals[3] <= pcst_pkg::RST_TIMED;
			s.vals[4] <= pcst_pkg::RST_TIMED;
		end else begin
			s <= next_s;
		end
	end

	assign O_PRDATA = s.prdata;
	assign O_PREADY = s.pready;
	assign O_PSLVERR = s.pslverr;
	assign O_OUT1 = s.out1;
	assign O_OUT2 = s.out2;
	assign O_OUT_CLEAR = s.out_clear;
	assign O_UNIT_RESET = s.unit_reset;
	assign O_PHASE = s.phase;
	assign O_WALK_DIGIT = s.walk;
	assign O_ST_DIGITS = s.st_digits;
	assign O_MODE = s.mode;
	assign O_COUNT_ADD = s.add;
	assign O_PRESET_ONE = s.vals[0];
	assign O_PRESET_TWO = s.vals[1];
	assign O_TIMED_ONE = s.vals[3];
	assign O_TIMED_TWO = s.vals[4];
	assign O_PRESCALE_EDIT_OK = s.edit_ok;

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);

	AST_ENTRY: assert property (s.phase == pcst_pkg::PH_IDLE && I_BTN[5]
		&& I_BTN[4] && !s.btn_q[5] && !s.btn_q[7] && !I_BTN[7]
		|=> O_PHASE == 2'h1 && O_WALK_DIGIT == 6'h20)
		else $error("entry pair did not start the digit walk");
	AST_WALK_HOLD: assert property (s.phase == pcst_pkg::PH_WALK
		&& I_BTN == s.btn_q && !tick |=> $stable(O_WALK_DIGIT))
		else $error("digit walk moved without tick or button");
	AST_OUT_HOLD: assert property (s.phase == pcst_pkg::PH_WALK
		|=> $stable(O_OUT1) && $stable(O_OUT2) || O_UNIT_RESET)
		else $error("untested output changed during self-test");
	AST_OUT_OFF: assert property (s.phase == pcst_pkg::PH_MODE && s.tested
		&& next_s.phase == pcst_pkg::PH_IDLE
		|=> !O_OUT1 && !O_OUT2 && O_OUT_CLEAR)
		else $error("tested outputs not forced off at exit");
	AST_ADVANCE: assert property (s.phase == pcst_pkg::PH_WALK && s.armed
		&& s.btn_q[2] && !I_BTN[2] |=> O_WALK_DIGIT == $past(s.walk) >> 1)
		else $error("button release did not advance the walk");
	AST_RESET_BTN: assert property (I_BTN[7] && !s.btn_q[7] && !I_DIP_SW[1]
		&& !I_BTN[0] && !I_BTN[1] |=> O_UNIT_RESET && O_PHASE == 2'h0)
		else $error("reset button did not reset the unit");
	AST_RESET_EXCEPT: assert property (I_BTN[7] && !s.btn_q[7] && I_BTN[0]
		|=> !O_UNIT_RESET)
		else $error("reset acted during timed output entry");
	AST_STATUS: assert property (s.phase == pcst_pkg::PH_STATUS
		&& $past(s.phase) == pcst_pkg::PH_WALK |-> O_ST_DIGITS
		== {2'b00, !$past(I_DIP_SW[6]), !$past(I_PROGRAM_LOCK_INPUT)})
		else $error("status digits wrong");
	AST_MODE_FROZEN: assert property (s.phase == pcst_pkg::PH_MODE
		&& $past(s.phase) == pcst_pkg::PH_MODE |-> $stable(O_MODE))
		else $error("applied mode changed during self-test");
	AST_LOCK_BLOCK: assert property (s.phase == pcst_pkg::PH_MODE && !s.tested
		&& !I_PROGRAM_LOCK_INPUT && !I_BTN[7] |=> !s.tested)
		else $error("output test ran with lock input low");
	AST_TIMEOUT: assert property (s.phase == pcst_pkg::PH_MODE && tick
		&& !activity && s.sec_cnt == pcst_pkg::IDLE_TICKS - 11'h001
		|=> O_PHASE == 2'h0)
		else $error("idle timeout did not end self-test");
	AST_PS_REFUSE: assert property (I_PSEL && !I_PENABLE && I_PWRITE
		&& I_PADDR == pcst_pkg::OFF_PRESCALE && !I_DIP_SW[6]
		|=> O_PSLVERR)
		else $error("prescale write not refused");
	AST_SCALE_ONE: assert property (I_COUNT_PULSE
		&& s.vals[2] == pcst_pkg::RST_PRESCALE |=> O_COUNT_ADD == 4'h1)
		else $error("unit prescale did not give one count");

	COV_STATUS: cover property (s.phase == pcst_pkg::PH_WALK
		##1 s.phase == pcst_pkg::PH_STATUS);
	COV_TESTED_EXIT: cover property (s.tested ##1 O_OUT_CLEAR);
	COV_TIMEOUT: cover property (s.phase == pcst_pkg::PH_MODE && !s.tested
		##1 s.phase == pcst_pkg::PH_IDLE);
endmodule // pcst_top
